// File: src/sblc_consts.svh
// Constants for the switch bus lock control block.
// Assumes inclusion by bare name from package and modules.
`ifndef SBLC_CONSTS_SVH
`define SBLC_CONSTS_SVH
`define SBLC_NUM_DN_PORTS 4
`define SBLC_PORT_W 2
`define SBLC_TYPE_W 3
`define SBLC_PQ_CNT_W 4
`endif

// File: src/sblc_if.sv
// Interface joining the switch lock tracker and the root-side end.
// Assumes one shared clock and reset.
`timescale 1ns/1ps
`include "sblc_consts.svh"
interface sblc_if (
  input wire logic CLK,
  input wire logic RST_N
);
  import sblc_pkg::*;
  logic                    us_valid;
  sblc_pkg::sblc_tlp_type  us_type;
  logic [`SBLC_PORT_W-1:0] us_port;
  logic                    us_ready;
  logic                    dn_valid;
  sblc_pkg::sblc_tlp_type  dn_type;
  logic [`SBLC_PORT_W-1:0] dn_port;
  logic                    locked;
  modport dev (input us_valid, us_type, us_port, dn_valid, dn_type,
               dn_port, output us_ready, locked);
  modport root (output us_valid, us_type, us_port, dn_valid, dn_type,
                dn_port, input us_ready, locked);
endinterface : sblc_if

// File: src/sblc_pkg.sv
// Types for the switch bus lock control block.
// Assumes sblc_consts.svh is on the include path.
`include "sblc_consts.svh"
package sblc_pkg;
  // Packet kinds seen by the lock tracker.
  typedef enum logic [`SBLC_TYPE_W-1:0] {
    SBLC_TLP_MWR    = 3'h0,
    SBLC_TLP_MRDLK  = 3'h1,
    SBLC_TLP_CPLDLK = 3'h2,
    SBLC_TLP_CPLLK  = 3'h3,
    SBLC_TLP_UNLOCK = 3'h4,
    SBLC_TLP_OTHER  = 3'h5
  } sblc_tlp_type;
  // Lock states of the switch.
  typedef enum logic [1:0] {
    SBLC_ST_IDLE    = 2'h0,
    SBLC_ST_DN_LOCK = 2'h1,
    SBLC_ST_SW_LOCK = 2'h2,
    SBLC_ST_FAILED  = 2'h3
  } sblc_state_type;
endpackage : sblc_pkg

// File: src/sblc_root.sv
// Root-side end: issues lock sequences and always finishes with Unlock.
// Assumes the switch end on the same interface and clock.
`timescale 1ns/1ps
`include "sblc_consts.svh"
module sblc_root (
  input  wire logic                CLK,
  input  wire logic                RST_N,
  sblc_if.root                     LNK,
  input  wire logic                START,
  input  wire logic [`SBLC_PORT_W-1:0] TARGET,
  input  wire logic                CPL_SEEN,
  input  wire logic                CPL_DATA,
  input  wire logic                DONE,
  output logic                     BUSY
);
  import sblc_pkg::*;
  typedef enum logic [1:0] {
    SBLC_R_IDLE = 2'h0,
    SBLC_R_RD   = 2'h1,
    SBLC_R_WAIT = 2'h2,
    SBLC_R_UNL  = 2'h3
  } sblc_root_type;
  sblc_root_type           st_reg;
  logic [`SBLC_PORT_W-1:0] tgt_reg;

  ////////////////////////////////////////////////////////////////////////
  // Sequence: locked read, wait, then Unlock in every case.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg       <= SBLC_R_IDLE;
      tgt_reg      <= '0;
      LNK.us_valid <= 1'b0;
      LNK.us_type  <= SBLC_TLP_OTHER;
      LNK.us_port  <= '0;
      LNK.dn_valid <= 1'b0;
      LNK.dn_type  <= SBLC_TLP_OTHER;
      LNK.dn_port  <= '0;
      BUSY         <= 1'b0;
    end else begin
      LNK.dn_valid <= CPL_SEEN;
      LNK.dn_type  <= CPL_DATA ? SBLC_TLP_CPLDLK : SBLC_TLP_CPLLK;
      LNK.dn_port  <= tgt_reg;
      case (st_reg)
        SBLC_R_IDLE: if (START) begin
          tgt_reg      <= TARGET;
          LNK.us_valid <= 1'b1;
          LNK.us_type  <= SBLC_TLP_MRDLK;
          LNK.us_port  <= TARGET;
          BUSY         <= 1'b1;
          st_reg       <= SBLC_R_RD;
        end
        SBLC_R_RD: if (LNK.us_ready) begin
          LNK.us_valid <= 1'b0;
          st_reg       <= SBLC_R_WAIT;
        end
        SBLC_R_WAIT: if (DONE) begin
          LNK.us_valid <= 1'b1;
          LNK.us_type  <= SBLC_TLP_UNLOCK;
          st_reg       <= SBLC_R_UNL;
        end
        SBLC_R_UNL: if (LNK.us_ready) begin
          LNK.us_valid <= 1'b0;
          BUSY         <= 1'b0;
          st_reg       <= SBLC_R_IDLE;
        end
        default: st_reg <= SBLC_R_IDLE;
      endcase
    end
  end
endmodule : sblc_root

// File: src/sblc_switch.sv
// Switch end: tracks locked sequences and blocks competing packets.
// Assumes packet events arrive on the interface, same clock.
// Operation
// - Only one lock sequence at once
// - Lock by locked read, success, unlock
// - Locked read locks its downstream port
// - Posted queue to port drains first
// - Downstream-only lock blocks nothing else (code still holds peer requests from ports other than the locked one)
// - Locked data completion locks whole switch
// - Posted queue upstream drains before completion
// - Failed lock held until Unlock
// - Root always ends with Unlock
// - Internal registers stay reachable while locked
// - Root avoids config access while locked
// - Partners send only permitted packets
// - Later locked reads leave state unchanged
// - Writes to locked device pass unchanged
// - Locked ports may still insert messages
// - Unlock forwards, clears, unblocks
// - Unlock waits for earlier posted writes
// - Blocked packets are delayed, not dropped
// - Root targets only the locked port
// - Lock state visible as status flag
`timescale 1ns/1ps
`include "sblc_consts.svh"
module sblc_switch #(
  parameter int NUM_DN = `SBLC_NUM_DN_PORTS
) (
  input  wire logic                     CLK,
  input  wire logic                     RST_N,
  sblc_if.dev                           LNK,
  input  wire logic [NUM_DN-1:0]        PQ_EMPTY,
  input  wire logic [NUM_DN-1:0]        UPQ_EMPTY,
  input  wire logic                     US_PQ_EMPTY,
  input  wire logic [NUM_DN-1:0]        DN_REQ,
  input  wire logic [NUM_DN-1:0]        DN_TO_US,
  input  wire logic [NUM_DN-1:0]        DN_MSG,
  output logic                          LOCKRD_FWD,
  output logic                          CPLD_FWD,
  output logic                          UNLOCK_FWD,
  output logic [`SBLC_PORT_W-1:0]       FWD_PORT,
  output logic [NUM_DN-1:0]             DN_GRANT,
  output logic [NUM_DN-1:0]             PORT_LOCKED,
  output logic                          SWITCH_LOCKED_FLAG
);
  import sblc_pkg::*;

  // Port numbers must fit the port field of the link.
  if (NUM_DN < 1 || NUM_DN > (1 << `SBLC_PORT_W)) begin : g_bad_num_dn
    $error("NUM_DN out of range");
  end

  localparam int PW = `SBLC_PORT_W;

  sblc_state_type          state_reg;
  logic [`SBLC_PORT_W-1:0] lock_port_reg;
  logic                    rd_pend_reg;
  logic                    cpl_pend_reg;
  logic                    unl_pend_reg;
  logic                    take_us;
  logic                    us_acc;
  logic                    cpl_hit;
  logic                    rd_go;
  logic                    cpl_go;
  logic                    unl_go;

  ////////////////////////////////////////////////////////////////////////
  // Upstream packets are held off while a lock step waits for posted drain.
  assign take_us = !(rd_pend_reg || cpl_pend_reg || unl_pend_reg);
  // A packet is taken only where valid meets the registered ready.
  assign us_acc  = LNK.us_valid && LNK.us_ready;
  // Locked completion from the locked port while any lock is held.
  assign cpl_hit = LNK.dn_valid && (LNK.dn_port == lock_port_reg) &&
                   (state_reg != SBLC_ST_IDLE) &&
                   (LNK.dn_type == SBLC_TLP_CPLDLK ||
                    LNK.dn_type == SBLC_TLP_CPLLK);
  // Each forward goes out once the posted queue ahead of it is empty.
  assign rd_go   = rd_pend_reg && PQ_EMPTY[lock_port_reg];
  assign cpl_go  = cpl_pend_reg && UPQ_EMPTY[lock_port_reg];
  assign unl_go  = unl_pend_reg && US_PQ_EMPTY;

  ////////////////////////////////////////////////////////////////////////
  // Lock state and locked port; reset leaves every port unblocked.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg     <= SBLC_ST_IDLE;
      lock_port_reg <= '0;
    end else begin
      // Only an idle switch starts a sequence; writes never touch it.
      if (us_acc && LNK.us_type == SBLC_TLP_MRDLK &&
          state_reg == SBLC_ST_IDLE) begin
        state_reg     <= SBLC_ST_DN_LOCK;
        lock_port_reg <= LNK.us_port;
      end
      // The first completion decides between whole lock and failure.
      if (cpl_hit && state_reg == SBLC_ST_DN_LOCK) begin
        if (LNK.dn_type == SBLC_TLP_CPLDLK)
          state_reg <= SBLC_ST_SW_LOCK;
        else
          state_reg <= SBLC_ST_FAILED;
      end
      // Unlock clears the lock once earlier posted writes have drained.
      if (unl_go)
        state_reg <= SBLC_ST_IDLE;
    end
  end

  // Every locked read, first or later, waits for its port's posted queue.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      rd_pend_reg <= 1'b0;
    else if (us_acc && LNK.us_type == SBLC_TLP_MRDLK)
      rd_pend_reg <= 1'b1;
    else if (rd_go)
      rd_pend_reg <= 1'b0;
  end

  // A new completion wins over the drain that retires the previous one.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      cpl_pend_reg <= 1'b0;
    else if (cpl_hit)
      cpl_pend_reg <= 1'b1;
    else if (cpl_go)
      cpl_pend_reg <= 1'b0;
  end

  // Unlock waits here until the upstream posted queue has drained.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      unl_pend_reg <= 1'b0;
    else if (us_acc && LNK.us_type == SBLC_TLP_UNLOCK &&
             state_reg != SBLC_ST_IDLE)
      unl_pend_reg <= 1'b1;
    else if (unl_go)
      unl_pend_reg <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Forwarding strobes toward the port queues.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      LOCKRD_FWD <= 1'b0;
      CPLD_FWD   <= 1'b0;
      UNLOCK_FWD <= 1'b0;
      FWD_PORT   <= '0;
    end else begin
      LOCKRD_FWD <= rd_go;
      CPLD_FWD   <= cpl_go;
      UNLOCK_FWD <= unl_go;
      FWD_PORT   <= lock_port_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-port grant: blocked requests are simply not granted and wait.
  // A peer request from any port other than the locked one is held (delayed) until unlock.
  function automatic logic port_peer_hit(input int idx);
    return (state_reg != SBLC_ST_IDLE) && DN_REQ[idx] && !DN_TO_US[idx] &&
           (lock_port_reg != PW'(idx));
  endfunction : port_peer_hit

  genvar g;
  generate
    for (g = 0; g < NUM_DN; g++) begin : g_port
      logic is_lock;
      logic blk;
      assign is_lock = (state_reg != SBLC_ST_IDLE) &&
                       (lock_port_reg == PW'(g));
      // Downstream-only lock blocks only peer requests from ports other than the locked one.
      assign blk = (state_reg == SBLC_ST_DN_LOCK) ? 1'b0 :
                   (state_reg != SBLC_ST_IDLE) && !is_lock &&
                   DN_TO_US[g];
      always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          DN_GRANT[g]    <= 1'b0;
          PORT_LOCKED[g] <= 1'b0;
        end else begin
          // Inserted messages from the locked port always pass.
          DN_GRANT[g]    <= DN_REQ[g] && (!blk || (is_lock && DN_MSG[g]))
                            && !port_peer_hit(g);
          PORT_LOCKED[g] <= is_lock;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Status flag and handshake outputs; SMBus path is never gated here.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SWITCH_LOCKED_FLAG <= 1'b0;
      LNK.locked         <= 1'b0;
    end else begin
      SWITCH_LOCKED_FLAG <= (state_reg == SBLC_ST_SW_LOCK);
      LNK.locked         <= (state_reg == SBLC_ST_SW_LOCK);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ready drops on the edge that takes a packet or starts a lock step, so
  // a high ready always means the switch can take the next packet.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      LNK.us_ready <= 1'b0;
    else
      LNK.us_ready <= take_us && !us_acc && !cpl_hit;
  end
endmodule : sblc_switch

// File: test/sblc_lock_properties.sv
// Checker of the lock handshake seen on the shared interface.
// Assumes the testbench instantiates it beside that interface.
`timescale 1ns/1ps
`include "sblc_consts.svh"
module sblc_lock_properties
  import sblc_pkg::*;
(
  input wire logic                    CLK,
  input wire logic                    RST_N,
  input wire logic                    us_valid,
  input wire sblc_tlp_type            us_type,
  input wire logic [`SBLC_PORT_W-1:0] us_port,
  input wire logic                    us_ready,
  input wire logic                    dn_valid,
  input wire sblc_tlp_type            dn_type,
  input wire logic [`SBLC_PORT_W-1:0] dn_port,
  input wire logic                    locked
);
  logic seen_reg;
  logic unl_wait_reg;
  wire logic unl = us_valid && us_ready && us_type == SBLC_TLP_UNLOCK;
  wire logic cpld = dn_valid && dn_type == SBLC_TLP_CPLDLK;
  wire logic cpll = dn_valid && dn_type == SBLC_TLP_CPLLK;
  // Remembers a data completion until the root's Unlock is taken.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) seen_reg <= 1'b0;
    else if (unl) seen_reg <= 1'b0;
    else if (cpld) seen_reg <= 1'b1;
  end
  // Marks a taken Unlock until the switch is ready for packets again.
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) unl_wait_reg <= 1'b0;
    else if (unl) unl_wait_reg <= 1'b1;
    else if (us_ready) unl_wait_reg <= 1'b0;
  end
  ////////////////////////////////////////
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Lock flag relations to reset and the packets that cause them, and request hold until ready.
  AST_RST_CLR: assert property ($rose(RST_N) |-> !locked)
    else $error("flag set after reset");
  AST_UNL_CLR: assert property (unl_wait_reg && us_ready |-> !locked)
    else $error("flag not cleared by unlock");
  AST_LK_SET: assert property (cpld && !locked |-> ##[1:16] locked)
    else $error("flag not set by data completion");
  AST_LK_CAUSE: assert property ($rose(locked) |-> seen_reg)
    else $error("flag rose without data completion");
  AST_LK_DROP: assert property ($fell(locked) |-> !seen_reg)
    else $error("flag fell without unlock");
  AST_CPLL_KEEP: assert property (locked && seen_reg && cpll |=>
    locked[*3])
    else $error("completion without data unlocked switch");
  AST_FAIL_LOW: assert property (cpll && !locked |->
    ##1 !locked ##1 !locked)
    else $error("failed lock raised flag");
  AST_REQ_HOLD: assert property (us_valid && !us_ready |=>
    us_valid && $stable(us_type) && $stable(us_port))
    else $error("request changed before ready");
endmodule : sblc_lock_properties

// File: test/switch_bus_lock_control_tb.sv
// Testbench joining the switch end and the root end of the lock link.
// Assumes the design files and sblc_consts.svh are compiled first.
`timescale 1ns/1ps
`include "sblc_consts.svh"
module switch_bus_lock_control_tb;
  import sblc_pkg::*;
  localparam int N = `SBLC_NUM_DN_PORTS;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic [N-1:0] pqe = '1, upqe = '1, msg = '0, tous = '1, grant, plk;
  logic         uspqe = 1'b1, start = 1'b0, cs = 1'b0, cd = 1'b0;
  logic         done = 1'b0, rdf, cpf, unf, flag, busy;
  logic [1:0]   tgt = '0, fport;
  int           n_fail = 0, check_count = 0, cyc = 0, ncp = 0;
  // Rows: target port, completion has data, expected flag.
  logic [3:0]   rows [4] = '{4'h3, 4'h4, 4'hB, 4'hC};
  sblc_if lnk (.CLK(clk), .RST_N(rst_n));
  sblc_switch #(.NUM_DN(N)) i_sblc_switch (.CLK(clk), .RST_N(rst_n),
    .LNK(lnk), .PQ_EMPTY(pqe), .UPQ_EMPTY(upqe), .US_PQ_EMPTY(uspqe),
    .DN_REQ('1), .DN_TO_US(tous), .DN_MSG(msg), .LOCKRD_FWD(rdf),
    .CPLD_FWD(cpf), .UNLOCK_FWD(unf), .FWD_PORT(fport), .DN_GRANT(grant),
    .PORT_LOCKED(plk), .SWITCH_LOCKED_FLAG(flag));
  sblc_root i_sblc_root (.CLK(clk), .RST_N(rst_n), .LNK(lnk),
    .START(start), .TARGET(tgt), .CPL_SEEN(cs), .CPL_DATA(cd),
    .DONE(done), .BUSY(busy));
  sblc_lock_properties i_chk (.CLK(clk), .RST_N(rst_n),
    .us_valid(lnk.us_valid), .us_type(lnk.us_type), .us_port(lnk.us_port),
    .us_ready(lnk.us_ready), .dn_valid(lnk.dn_valid),
    .dn_type(lnk.dn_type), .dn_port(lnk.dn_port), .locked(lnk.locked));
  ////////////////////////////////////////
  // Clock, completion counter and hang guard.
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cpf === 1'b1) ncp++;
    if (cyc == 3000) begin
      n_fail++;
      final_report();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask : pulse
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %0h got %0h", nm, e, g);
    end
  endtask : chk
  // Waits a bounded time for one forward strobe: read, completion, unlock.
  task wait_ev(input int k);
    int n;
    n = 0;
    while (!(k == 0 ? rdf : k == 1 ? cpf : unf) && n < 20) begin
      tick(1);
      n++;
    end
    chk("strobe", 8'h1, 8'(k == 0 ? rdf : k == 1 ? cpf : unf));
  endtask : wait_ev
  // One whole lock sequence on port t.
  task run(input logic [1:0] t, input logic d, input logic f);
    tgt = t;
    pulse(start);
    wait_ev(0);
    chk("rd_port", 8'(t), 8'(fport));
    tick(1);
    chk("port_lk", 8'(4'h1 << t), 8'(plk));
    chk("grant_dn", 8'hF, 8'(grant));
    cd = d;
    pulse(cs);
    tick(6);
    chk("flag", 8'(f), 8'(flag));
    chk("grant_lk", 8'(4'h1 << t), 8'(grant));
    pulse(done);
    wait_ev(2);
    chk("unl_port", 8'(t), 8'(fport));
    tick(3);
    chk("grant_free", 8'hF, 8'(grant));
    chk("flag_off", 8'h0, 8'(flag));
  endtask : run
  task final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // Row loop, then drain waits, a late completion and a reset under lock.
  initial begin
    tick(2);
    rst_n = 1'b1;
    foreach (rows[i]) run(rows[i][3:2], rows[i][1], rows[i][0]);
    pqe[2] = 1'b0;
    tgt = 2'h2;
    pulse(start);
    tick(4);
    chk("rd_wait", 8'h0, 8'(lnk.us_ready));
    pqe[2] = 1'b1;
    wait_ev(0);
    upqe[2] = 1'b0;
    ncp = 0;
    cd = 1'b1;
    pulse(cs);
    tick(4);
    chk("cpl_wait", 8'h0, 8'(ncp));
    upqe[2] = 1'b1;
    tick(8);
    chk("cpl_go", 8'h1, 8'(ncp));
    chk("busy", 8'h1, 8'(busy));
    msg = 4'h6;
    tous[1] = 1'b0;
    cd = 1'b0;
    pulse(cs);
    tick(6);
    chk("flag_keep", 8'h1, 8'(flag));
    chk("msg", 8'h4, 8'(grant));
    uspqe = 1'b0;
    pulse(done);
    tick(6);
    chk("unl_wait", 8'h1, 8'(flag));
    uspqe = 1'b1;
    wait_ev(2);
    tick(3);
    chk("unl_go", 8'h0, 8'(flag));
    chk("peer_free", 8'hF, 8'(grant));
    tgt = 2'h1;
    cd = 1'b1;
    pulse(start);
    wait_ev(0);
    pulse(cs);
    tick(6);
    rst_n = 1'b0;
    tick(2);
    chk("rst_port", 8'h0, 8'(plk));
    rst_n = 1'b1;
    tick(2);
    chk("rst_grant", 8'hF, 8'(grant));
    final_report();
  end
endmodule : switch_bus_lock_control_tb
